/* rtl/iprr_consts.svh */
`ifndef IPRR_CONSTS_SVH
`define IPRR_CONSTS_SVH
// What this block does
// - An encoded external level 0 to 14 maps to code 0x200 plus 0x20 per step, priority 15 down.
// - Bit 0 of the group-8 flag register is set by the SD host request and stays 1 until a 0 is written or reset.
// - The group-9 flag register is 8 bits and gathers PC card, USB host, USB function and timer.
// - Flag registers of groups 2, 8 and 9 clear to zero on resets and hold through standby.
// - Without the SD host its flag bit reads 0 and software writes only 0 there.
// - SD host priority register: bits 7-4 SD host level, 3-0 front end level, 15-12 reserved.
// - Line/timer priority register: bits 7-4 line five, 3-0 line four, 15-12 reserved.
// - Serial priority register: bits 15-12 serial port zero, bits 11-0 reserved as zero.
// - The timer capture interrupt uses code 0x6c0 with level from line/timer bits 11-8.
// - DMA end channels 4 and 5 use 0xb80 and 0xba0, share one level, channel 4 wins.
// - The USB host interrupt takes its level from SD host priority bits 11-8.
// - With the clock supplied, a port-pin interrupt wakes standby only above the CPU mask.
// - Standby wakes on NMI, edge lines, clock, timer, port pin or reset; maskable need the clock.
`define IPRR_OFF_PRIO_EXT 12'h000
`define IPRR_OFF_PRIO_SER 12'h004
`define IPRR_OFF_PRIO_SDH 12'h008
`define IPRR_OFF_PRIO_DMA 12'h00c
`define IPRR_OFF_REQ_G0 12'h010
`define IPRR_OFF_REQ_G2 12'h014
`define IPRR_OFF_REQ_G8 12'h018
`define IPRR_OFF_REQ_G9 12'h01c
`define IPRR_OFF_STATUS 12'h020
`define IPRR_OFF_PORT_PIN_IRQ_LVL 12'h024
`define IPRR_MASK_EXT 16'h0fff
`define IPRR_MASK_SER 16'hf000
`define IPRR_MASK_SDH 16'h0fff
`define IPRR_MASK_DMA 16'h0f00
`define IPRR_PRIO_RST 16'h0000
`define IPRR_FLAGS_RST 8'h00
`define IPRR_BIT_SDHOST 0
`define IPRR_BIT_CRYPTO 4
`define IPRR_CODE_LVL_BASE 12'h200
`define IPRR_CODE_LVL_STEP 12'h020
`define IPRR_LVL_NONE 4'hf
`define IPRR_PRIO_TOP 4'hf
`define IPRR_CODE_TMR_CAP 12'h6c0
`define IPRR_CODE_DMA4 12'hb80
`define IPRR_CODE_DMA5 12'hba0
`define IPRR_CODE_USB_HOST_UNIT 12'h000
`define IPRR_LVL_MID 11:8
`define IPRR_ST_STANDBY 0
`define IPRR_ST_CODE 15:4
`define IPRR_ST_LEVEL 19:16
`define IPRR_ST_VALID 20
`endif

/* rtl/iprr_pkg.sv */
package iprr_pkg;
  typedef logic [11:0] iprr_code_t;
  typedef logic [3:0] iprr_lvl_t;
  typedef enum logic {IPRR_RUN, IPRR_STANDBY} iprr_pwr_e;
endpackage

/* rtl/iprr_req_if.sv */
`timescale 1ns/10ps
interface iprr_req_if;
  logic valid;
  iprr_pkg::iprr_code_t code;
  iprr_pkg::iprr_lvl_t lvl;
  modport src (output valid, output code, output lvl);
  modport dst (input valid, input code, input lvl);
endinterface

/* rtl/iprr_lvl_decode.sv */
`timescale 1ns/10ps
`include "iprr_consts.svh"
module iprr_lvl_decode (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [3:0] level_in,
  iprr_req_if.src req
);
  logic [3:0] sync1_reg, sync2_reg, sync1_next, sync2_next;
  always_comb begin
    sync1_next = level_in;
    sync2_next = sync1_reg;
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync1_reg <= `IPRR_LVL_NONE;
      sync2_reg <= `IPRR_LVL_NONE;
    end else begin
      sync1_reg <= sync1_next;
      sync2_reg <= sync2_next;
    end
  end
  always_comb begin
    req.valid = (sync2_reg != `IPRR_LVL_NONE);
    req.code = `IPRR_CODE_LVL_BASE + 12'(sync2_reg) * `IPRR_CODE_LVL_STEP;
    req.lvl = `IPRR_PRIO_TOP - sync2_reg;
  end
endmodule

/* rtl/iprr_arbiter.sv */
`timescale 1ns/10ps
`include "iprr_consts.svh"
module iprr_arbiter (
  input wire logic [15:0] prio_ext,
  input wire logic [15:0] prio_sdh,
  input wire logic [15:0] prio_dma,
  input wire logic tmr_cap,
  input wire logic dma4,
  input wire logic dma5,
  input wire logic usb_host_unit,
  iprr_req_if.dst lvl_req,
  iprr_req_if.src best
);
  // Fixed scan order; strictly greater keeps the earlier source on a tie
  always_comb begin
    best.valid = lvl_req.valid;
    best.code = lvl_req.code;
    best.lvl = lvl_req.lvl;
    if (tmr_cap && (!best.valid || prio_ext[`IPRR_LVL_MID] > best.lvl)) begin
      best.valid = 1'b1;
      best.code = `IPRR_CODE_TMR_CAP;
      best.lvl = prio_ext[`IPRR_LVL_MID];
    end
    if (dma4 && (!best.valid || prio_dma[`IPRR_LVL_MID] > best.lvl)) begin
      best.valid = 1'b1;
      best.code = `IPRR_CODE_DMA4;
      best.lvl = prio_dma[`IPRR_LVL_MID];
    end else if (dma5 && (!best.valid || prio_dma[`IPRR_LVL_MID] > best.lvl)) begin
      best.valid = 1'b1;
      best.code = `IPRR_CODE_DMA5;
      best.lvl = prio_dma[`IPRR_LVL_MID];
    end
    if (usb_host_unit && (!best.valid || prio_sdh[`IPRR_LVL_MID] > best.lvl)) begin
      best.valid = 1'b1;
      best.code = `IPRR_CODE_USB_HOST_UNIT;
      best.lvl = prio_sdh[`IPRR_LVL_MID];
    end
  end
endmodule

/* rtl/iprr_top.sv */
// Decided for this implementation: the register offsets and the APB interface to the registers.
`timescale 1ns/10ps
`include "iprr_consts.svh"
module iprr_top #(
  parameter bit HAS_SD_HOST = 1'b1,
  parameter bit HAS_CRYPTO = 1'b1
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [3:0] encoded_level_input,
  input wire logic [7:0] req_in_group0,
  input wire logic [7:0] req_in_group2,
  input wire logic [7:0] req_in_group8,
  input wire logic [7:0] req_in_group9,
  input wire logic timer_capture_irq,
  input wire logic dma_end_ch_four,
  input wire logic dma_end_ch_five,
  input wire logic usb_host_irq,
  input wire logic port_pin_irq,
  input wire logic nmi_edge,
  input wire logic ext_line_edge_irq,
  input wire logic rtc_irq,
  input wire logic timer_unit_irq,
  input wire logic rtc_running,
  input wire logic standby_enter,
  input wire logic [3:0] cpu_mask_level,
  output logic irq_valid,
  output logic [11:0] irq_code,
  output logic [3:0] irq_level,
  output logic standby_active,
  output logic wake_pulse
);
  iprr_req_if lvl_req ();
  iprr_req_if best ();

  logic [15:0] prio_ext_reg, prio_ext_next;
  logic [15:0] prio_ser_reg, prio_ser_next;
  logic [15:0] prio_sdh_reg, prio_sdh_next;
  logic [15:0] prio_dma_reg, prio_dma_next;
  logic [3:0] port_pin_irq_lvl_reg, port_pin_irq_lvl_next;
  logic [7:0] flags0_reg, flags0_next;
  logic [7:0] flags2_reg, flags2_next;
  logic [7:0] flags8_reg, flags8_next;
  logic [7:0] flags9_reg, flags9_next;
  logic [31:0] prdata_reg, prdata_next;
  logic pready_reg, pready_next;
  logic pslverr_reg, pslverr_next;
  logic irq_valid_reg, irq_valid_next;
  logic [11:0] irq_code_reg, irq_code_next;
  logic [3:0] irq_level_reg, irq_level_next;
  iprr_pkg::iprr_pwr_e pwr_reg, pwr_next;
  logic wake_reg, wake_next;
  logic [7:0] avail2, avail8;
  logic setup, wr, rd;
  logic [7:0] clr0, clr2, clr8, clr9;
  logic port_pin_irq_wake, any_wake;
  logic [31:0] status_word;
  logic addr_ok;

  iprr_lvl_decode u_dec (
    .pclk(pclk),
    .presetn(presetn),
    .level_in(encoded_level_input),
    .req(lvl_req)
  );

  iprr_arbiter u_arb (
    .prio_ext(prio_ext_reg),
    .prio_sdh(prio_sdh_reg),
    .prio_dma(prio_dma_reg),
    .tmr_cap(timer_capture_irq),
    .dma4(dma_end_ch_four),
    .dma5(dma_end_ch_five),
    .usb_host_unit(usb_host_irq),
    .lvl_req(lvl_req),
    .best(best)
  );

  always_comb begin
    avail2 = 8'hff;
    avail2[`IPRR_BIT_CRYPTO] = HAS_CRYPTO;
    avail8 = 8'hff;
    avail8[`IPRR_BIT_SDHOST] = HAS_SD_HOST;
  end

  // One wait state: read data is captured in the first access cycle, a write lands
  // only at the edge that completes the transfer
  always_comb begin
    setup = psel && penable && !pready_reg;
    wr = psel && penable && pready_reg && pwrite;
    rd = setup && !pwrite;
    addr_ok = (paddr <= `IPRR_OFF_PORT_PIN_IRQ_LVL) && (paddr[1:0] == 2'h0);
  end

  // Writing 0 to a set flag clears it; a new request in that cycle wins
  always_comb begin
    clr0 = 8'h00;
    clr2 = 8'h00;
    clr8 = 8'h00;
    clr9 = 8'h00;
    if (wr && paddr == `IPRR_OFF_REQ_G0) begin
      clr0 = ~pwdata[7:0];
    end else if (wr && paddr == `IPRR_OFF_REQ_G2) begin
      clr2 = ~pwdata[7:0];
    end else if (wr && paddr == `IPRR_OFF_REQ_G8) begin
      clr8 = ~pwdata[7:0];
    end else if (wr && paddr == `IPRR_OFF_REQ_G9) begin
      clr9 = ~pwdata[7:0];
    end
  end

  // Reserved fields are forced to zero so they always read back as zero
  always_comb begin
    prio_ext_next = prio_ext_reg;
    prio_ser_next = prio_ser_reg;
    prio_sdh_next = prio_sdh_reg;
    prio_dma_next = prio_dma_reg;
    port_pin_irq_lvl_next = port_pin_irq_lvl_reg;
    if (wr && paddr == `IPRR_OFF_PRIO_EXT) begin
      prio_ext_next = pwdata[15:0] & `IPRR_MASK_EXT;
    end else if (wr && paddr == `IPRR_OFF_PRIO_SER) begin
      prio_ser_next = pwdata[15:0] & `IPRR_MASK_SER;
    end else if (wr && paddr == `IPRR_OFF_PRIO_SDH) begin
      prio_sdh_next = pwdata[15:0] & `IPRR_MASK_SDH;
    end else if (wr && paddr == `IPRR_OFF_PRIO_DMA) begin
      prio_dma_next = pwdata[15:0] & `IPRR_MASK_DMA;
    end else if (wr && paddr == `IPRR_OFF_PORT_PIN_IRQ_LVL) begin
      port_pin_irq_lvl_next = pwdata[3:0];
    end
  end

  // Flags are held through standby; reset or a write of 0 to a set flag clears them
  always_comb begin
    flags0_next = (flags0_reg & ~clr0) | req_in_group0;
    flags2_next = ((flags2_reg & ~clr2) | req_in_group2) & avail2;
    flags8_next = ((flags8_reg & ~clr8) | req_in_group8) & avail8;
    flags9_next = (flags9_reg & ~clr9) | req_in_group9;
  end

  // Read data is registered and stands with pready for one cycle
  always_comb begin
    prdata_next = prdata_reg;
    pslverr_next = 1'b0;
    pready_next = setup;
    if (rd) begin
      if (paddr == `IPRR_OFF_PRIO_EXT) begin
        prdata_next = {16'h0000, prio_ext_reg};
      end else if (paddr == `IPRR_OFF_PRIO_SER) begin
        prdata_next = {16'h0000, prio_ser_reg};
      end else if (paddr == `IPRR_OFF_PRIO_SDH) begin
        prdata_next = {16'h0000, prio_sdh_reg};
      end else if (paddr == `IPRR_OFF_PRIO_DMA) begin
        prdata_next = {16'h0000, prio_dma_reg};
      end else if (paddr == `IPRR_OFF_REQ_G0) begin
        prdata_next = {24'h000000, flags0_reg};
      end else if (paddr == `IPRR_OFF_REQ_G2) begin
        prdata_next = {24'h000000, flags2_reg};
      end else if (paddr == `IPRR_OFF_REQ_G8) begin
        prdata_next = {24'h000000, flags8_reg};
      end else if (paddr == `IPRR_OFF_REQ_G9) begin
        prdata_next = {24'h000000, flags9_reg};
      end else if (paddr == `IPRR_OFF_STATUS) begin
        prdata_next = status_word;
      end else if (paddr == `IPRR_OFF_PORT_PIN_IRQ_LVL) begin
        prdata_next = {28'h0000000, port_pin_irq_lvl_reg};
      end else begin
        prdata_next = 32'h00000000;
        pslverr_next = 1'b1;
      end
    end else if (setup) begin
      prdata_next = 32'h00000000;
      pslverr_next = !addr_ok || (paddr == `IPRR_OFF_STATUS);
    end
  end

  always_comb begin
    irq_valid_next = best.valid;
    irq_code_next = best.code;
    irq_level_next = best.lvl;
  end

  // Read-only view of the arbiter result and the power state
  always_comb begin
    status_word = 32'h00000000;
    status_word[`IPRR_ST_STANDBY] = (pwr_reg == iprr_pkg::IPRR_STANDBY);
    status_word[`IPRR_ST_CODE] = irq_code_reg;
    status_word[`IPRR_ST_LEVEL] = irq_level_reg;
    status_word[`IPRR_ST_VALID] = irq_valid_reg;
  end

  // Maskable wake sources count only while the real-time clock runs
  always_comb begin
    port_pin_irq_wake = rtc_running && port_pin_irq && (port_pin_irq_lvl_reg > cpu_mask_level);
    any_wake = nmi_edge || port_pin_irq_wake
               || (rtc_running && (ext_line_edge_irq || rtc_irq || timer_unit_irq));
  end

  always_comb begin
    pwr_next = pwr_reg;
    wake_next = 1'b0;
    case (pwr_reg)
      iprr_pkg::IPRR_RUN: begin
        if (standby_enter) begin
          pwr_next = iprr_pkg::IPRR_STANDBY;
        end
      end
      iprr_pkg::IPRR_STANDBY: begin
        if (any_wake) begin
          pwr_next = iprr_pkg::IPRR_RUN;
          wake_next = 1'b1;
        end
      end
      default: pwr_next = iprr_pkg::IPRR_RUN;
    endcase
  end

  // Priority fields
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prio_ext_reg <= `IPRR_PRIO_RST;
      prio_ser_reg <= `IPRR_PRIO_RST;
      prio_sdh_reg <= `IPRR_PRIO_RST;
      prio_dma_reg <= `IPRR_PRIO_RST;
      port_pin_irq_lvl_reg <= 4'h0;
    end else begin
      prio_ext_reg <= prio_ext_next;
      prio_ser_reg <= prio_ser_next;
      prio_sdh_reg <= prio_sdh_next;
      prio_dma_reg <= prio_dma_next;
      port_pin_irq_lvl_reg <= port_pin_irq_lvl_next;
    end
  end

  // Request flags have no standby branch, so standby leaves them as they are
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flags0_reg <= `IPRR_FLAGS_RST;
      flags2_reg <= `IPRR_FLAGS_RST;
      flags8_reg <= `IPRR_FLAGS_RST;
      flags9_reg <= `IPRR_FLAGS_RST;
    end else begin
      flags0_reg <= flags0_next;
      flags2_reg <= flags2_next;
      flags8_reg <= flags8_next;
      flags9_reg <= flags9_next;
    end
  end

  // Bus answer
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_reg <= 32'h00000000;
      pready_reg <= 1'b0;
      pslverr_reg <= 1'b0;
    end else begin
      prdata_reg <= prdata_next;
      pready_reg <= pready_next;
      pslverr_reg <= pslverr_next;
    end
  end

  // Registered arbiter result
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_valid_reg <= 1'b0;
      irq_code_reg <= 12'h000;
      irq_level_reg <= 4'h0;
    end else begin
      irq_valid_reg <= irq_valid_next;
      irq_code_reg <= irq_code_next;
      irq_level_reg <= irq_level_next;
    end
  end

  // Power state and wake pulse
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pwr_reg <= iprr_pkg::IPRR_RUN;
      wake_reg <= 1'b0;
    end else begin
      pwr_reg <= pwr_next;
      wake_reg <= wake_next;
    end
  end

  always_comb begin
    prdata = prdata_reg;
    pready = pready_reg;
    pslverr = pslverr_reg;
    irq_valid = irq_valid_reg;
    irq_code = irq_code_reg;
    irq_level = irq_level_reg;
    standby_active = (pwr_reg == iprr_pkg::IPRR_STANDBY);
    wake_pulse = wake_reg;
  end
endmodule

/* test/iprr_properties.sv */
`timescale 1ns/10ps
module iprr_properties (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [3:0] encoded_level_input,
  input wire logic timer_capture_irq,
  input wire logic dma_end_ch_four,
  input wire logic dma_end_ch_five,
  input wire logic usb_host_irq,
  input wire logic nmi_edge,
  input wire logic rtc_running,
  input wire logic irq_valid,
  input wire logic [11:0] irq_code,
  input wire logic [3:0] irq_level,
  input wire logic standby_active,
  input wire logic wake_pulse
);
  logic [2:0] age_reg;
  logic [2:0] age_next;
  logic [3:0] srcs;
  assign srcs = {timer_capture_irq, dma_end_ch_four, dma_end_ch_five, usb_host_irq};
  always_comb begin
    age_next = (age_reg == 3'h7) ? age_reg : age_reg + 3'h1;
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      age_reg <= 3'h0;
    end else begin
      age_reg <= age_next;
    end
  end
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  // Encoded input steady through the synchroniser, other sources idle
  sequence enc_held;
    age_reg == 3'h7 && srcs == 4'h0 && $past(srcs) == 4'h0 && $past(srcs, 2) == 4'h0
      && $past(encoded_level_input, 2) == $past(encoded_level_input)
      && $past(encoded_level_input, 3) == $past(encoded_level_input)
      && $past(encoded_level_input, 4) == $past(encoded_level_input);
  endsequence
  sequence only(logic [3:0] s);
    (srcs == s && encoded_level_input == 4'hf)[*5];
  endsequence
  a_enc_code_map: assert property (enc_held ##0 $past(encoded_level_input) != 4'hf
    |-> irq_valid && irq_code == 12'h200 + {$past(encoded_level_input), 5'h00}
    && irq_level == 4'hf - $past(encoded_level_input)) else $error("encoded level map wrong");
  a_enc_none_idle: assert property (enc_held ##0 $past(encoded_level_input) == 4'hf
    |-> !irq_valid) else $error("all-ones level raised a request");
  a_tmr_cap_code: assert property (only(4'b1000) |-> irq_valid && irq_code == 12'h6c0)
    else $error("timer capture code wrong");
  a_dma_four_wins: assert property (only(4'b0110) |-> irq_code == 12'hb80)
    else $error("dma channel four did not win");
  a_dma_five_code: assert property (only(4'b0010) |-> irq_code == 12'hba0)
    else $error("dma channel five code wrong");
  a_code_level_pair: assert property (irq_valid && irq_code[11:9] == 3'h1
    |-> irq_level == 4'hf - irq_code[8:5]) else $error("level does not match code");
  a_nmi_wakes: assert property (standby_active && nmi_edge
    |=> wake_pulse && !standby_active) else $error("nmi did not wake");
  a_no_clock_stays: assert property (standby_active && !rtc_running && !nmi_edge
    |=> standby_active && !wake_pulse) else $error("woke without clock");
  a_wake_cause: assert property (wake_pulse |-> !standby_active && $past(standby_active))
    else $error("wake pulse outside standby");
  a_apb_one_wait: assert property (psel && penable && !pready |=> pready)
    else $error("apb answer late");
  a_ready_pulse: assert property (pready |=> !pready) else $error("ready held");
  a_err_with_ready: assert property (pslverr |-> pready) else $error("error without ready");
  c_enc_req: cover property (irq_valid && irq_code[11:9] == 3'h1);
  c_wake: cover property (wake_pulse);
  c_err: cover property (pslverr);
endmodule
bind iprr_top iprr_properties u_props (.pclk, .presetn, .psel, .penable, .pready, .pslverr,
  .encoded_level_input, .timer_capture_irq, .dma_end_ch_four, .dma_end_ch_five, .usb_host_irq,
  .nmi_edge, .rtc_running, .irq_valid, .irq_code, .irq_level, .standby_active, .wake_pulse);

/* test/iprr_periph_model.sv */
`timescale 1ns/10ps
module iprr_periph_model (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [31:0] events,
  input wire logic [3:0] mask_set,
  output logic [7:0] req_in_group0,
  output logic [7:0] req_in_group2,
  output logic [7:0] req_in_group8,
  output logic [7:0] req_in_group9,
  output logic [3:0] cpu_mask_level
);
  logic [35:0] out_reg;
  logic [35:0] out_next;
  // Peripherals raise one-cycle request events; the core updates its mask a cycle late
  always_comb begin
    out_next = {mask_set, events};
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      out_reg <= 36'h0;
    end else begin
      out_reg <= out_next;
    end
  end
  assign {cpu_mask_level, req_in_group9, req_in_group8, req_in_group2, req_in_group0} = out_reg;
endmodule

/* test/irq_priority_request_regs_tb_top.sv */
`timescale 1ns/10ps
`include "iprr_consts.svh"
module irq_priority_request_regs_tb_top;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
  logic [11:0] paddr, irq_code;
  logic [31:0] pwdata, prdata, rd, events;
  logic [3:0] encoded_level_input, cpu_mask_level, mask_set, irq_level;
  logic [7:0] req_in_group0, req_in_group2, req_in_group8, req_in_group9;
  logic timer_capture_irq, dma_end_ch_four, dma_end_ch_five, usb_host_irq, port_pin_irq;
  logic nmi_edge, ext_line_edge_irq, rtc_irq, timer_unit_irq, rtc_running, standby_enter;
  logic irq_valid, standby_active, wake_pulse;
  int n_fail;
  int compares;
  iprr_top DUT (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .encoded_level_input, .req_in_group0, .req_in_group2, .req_in_group8,
    .req_in_group9, .timer_capture_irq, .dma_end_ch_four, .dma_end_ch_five, .usb_host_irq,
    .port_pin_irq, .nmi_edge, .ext_line_edge_irq, .rtc_irq, .timer_unit_irq, .rtc_running,
    .standby_enter, .cpu_mask_level, .irq_valid, .irq_code, .irq_level, .standby_active,
    .wake_pulse);
  iprr_periph_model u_peri (.pclk, .presetn, .events, .mask_set, .req_in_group0,
    .req_in_group2, .req_in_group8, .req_in_group9, .cpu_mask_level);
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end
  task end_of_test();
    $display("compares %0d n_fail %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      n_fail++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task tick(input int n);
    repeat (n) @(posedge pclk);
  endtask
  task xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
    int i;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    i = 0;
    do begin
      @(posedge pclk);
      i++;
    end while (pready !== 1'b1 && i < 20);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (i >= 20) begin
      chk("pready", pready, 1'b1);
      end_of_test();
    end
    // Idle edge so a following call never re-drives psel in this time step
    @(posedge pclk);
  endtask
  task rdchk(input string nm, input logic [11:0] a, input logic [31:0] exp);
    xfer(1'b0, a, 32'h0);
    chk(nm, rd, exp);
  endtask
  task wait_wake(input string nm);
    int i;
    for (i = 0; i < 10 && wake_pulse !== 1'b1; i++) begin
      @(posedge pclk);
    end
    chk(nm, wake_pulse, 1'b1);
    chk("standby_active", standby_active, 1'b0);
    if (wake_pulse !== 1'b1) begin
      end_of_test();
    end
  endtask
  task t_regs();
    rdchk("prio_ext", `IPRR_OFF_PRIO_EXT, 32'h0);
    rdchk("req_g2", `IPRR_OFF_REQ_G2, 32'h0);
    rdchk("req_g8", `IPRR_OFF_REQ_G8, 32'h0);
    rdchk("req_g9", `IPRR_OFF_REQ_G9, 32'h0);
    xfer(1'b1, `IPRR_OFF_PRIO_EXT, 32'hffffffff);
    rdchk("prio_ext", `IPRR_OFF_PRIO_EXT, 32'h0fff);
    xfer(1'b1, `IPRR_OFF_PRIO_SER, 32'hffffffff);
    rdchk("prio_ser", `IPRR_OFF_PRIO_SER, 32'hf000);
    xfer(1'b1, `IPRR_OFF_PRIO_SDH, 32'hffffffff);
    rdchk("prio_sdh", `IPRR_OFF_PRIO_SDH, 32'h0fff);
    xfer(1'b0, 12'h030, 32'h0);
    chk("unmapped pslverr", err, 1'b1);
    $display("test regs done");
  endtask
  task t_enc();
    for (int v = 0; v < 16; v++) begin
      encoded_level_input <= v[3:0];
      tick(6);
      chk("irq_valid", irq_valid, v < 15);
      if (v < 15) begin
        chk("irq_code", irq_code, 12'h200 + v * 12'h20);
        chk("irq_level", irq_level, 4'hf - v[3:0]);
      end
    end
    $display("test encoded level done");
  endtask
  task src(input logic [3:0] s, input logic [11:0] c, input logic [3:0] l);
    {timer_capture_irq, dma_end_ch_four, dma_end_ch_five, usb_host_irq} <= s;
    tick(5);
    chk("irq_code", irq_code, c);
    chk("irq_level", irq_level, l);
    {timer_capture_irq, dma_end_ch_four, dma_end_ch_five, usb_host_irq} <= 4'h0;
    tick(2);
  endtask
  task t_src();
    xfer(1'b1, `IPRR_OFF_PRIO_EXT, 32'h0500);
    xfer(1'b1, `IPRR_OFF_PRIO_DMA, 32'h0700);
    xfer(1'b1, `IPRR_OFF_PRIO_SDH, 32'h0300);
    rdchk("prio_dma", `IPRR_OFF_PRIO_DMA, 32'h0700);
    src(4'b1000, 12'h6c0, 4'h5);
    src(4'b0110, 12'hb80, 4'h7);
    src(4'b0010, 12'hba0, 4'h7);
    src(4'b0001, `IPRR_CODE_USB_HOST_UNIT, 4'h3);
    $display("test sources done");
  endtask
  task t_flags();
    events <= 32'h00011000;
    tick(1);
    events <= 32'h0;
    tick(3);
    rdchk("req_g8", `IPRR_OFF_REQ_G8, 32'h01);
    rdchk("req_g2", `IPRR_OFF_REQ_G2, 32'h10);
    xfer(1'b1, `IPRR_OFF_REQ_G8, 32'hff);
    rdchk("req_g8", `IPRR_OFF_REQ_G8, 32'h01);
    xfer(1'b1, `IPRR_OFF_REQ_G8, 32'h00);
    rdchk("req_g8", `IPRR_OFF_REQ_G8, 32'h00);
    $display("test flags done");
  endtask
  task t_standby();
    events <= 32'h00010000;
    standby_enter <= 1'b1;
    tick(1);
    events <= 32'h0;
    standby_enter <= 1'b0;
    {port_pin_irq, ext_line_edge_irq, rtc_irq, timer_unit_irq} <= 4'hf;
    tick(4);
    chk("standby_active", standby_active, 1'b1);
    rdchk("req_g8", `IPRR_OFF_REQ_G8, 32'h01);
    {port_pin_irq, ext_line_edge_irq, rtc_irq, timer_unit_irq} <= 4'h0;
    nmi_edge <= 1'b1;
    tick(1);
    nmi_edge <= 1'b0;
    wait_wake("nmi wake");
    xfer(1'b1, `IPRR_OFF_PORT_PIN_IRQ_LVL, 32'h4);
    rtc_running <= 1'b1;
    mask_set <= 4'h4;
    standby_enter <= 1'b1;
    tick(1);
    standby_enter <= 1'b0;
    port_pin_irq <= 1'b1;
    tick(4);
    chk("standby_active", standby_active, 1'b1);
    mask_set <= 4'h3;
    wait_wake("port pin wake");
    port_pin_irq <= 1'b0;
    $display("test standby done");
  endtask
  task t_reset();
    events <= 32'h00010000;
    tick(1);
    events <= 32'h0;
    tick(2);
    presetn <= 1'b0;
    tick(5);
    presetn <= 1'b1;
    tick(1);
    rdchk("req_g8", `IPRR_OFF_REQ_G8, 32'h0);
    rdchk("prio_ext", `IPRR_OFF_PRIO_EXT, 32'h0);
    $display("test reset done");
  endtask
  initial begin
    n_fail = 0;
    compares = 0;
    {presetn, psel, penable, pwrite, paddr, pwdata, events, mask_set} = '0;
    encoded_level_input = 4'hf;
    {timer_capture_irq, dma_end_ch_four, dma_end_ch_five, usb_host_irq} = 4'h0;
    {port_pin_irq, nmi_edge, ext_line_edge_irq, rtc_irq, timer_unit_irq} = 5'h00;
    {rtc_running, standby_enter} = 2'h0;
    tick(5);
    presetn <= 1'b1;
    tick(1);
    t_regs();
    t_enc();
    t_src();
    t_flags();
    t_standby();
    t_reset();
    end_of_test();
  end
endmodule
